//--- design/dss_pkg.sv
// Shared constants and types for the sampling speed selector and its clock source
package dss_pkg;

    localparam int RATIO_W = 11;
    localparam int RATIO_N = 7;

    typedef enum logic [1:0] {
        SPD_NORMAL = 2'b00,
        SPD_DOUBLE = 2'b01,
        SPD_QUAD   = 2'b10
    } dss_speed_e;

    // Master clock to frame clock ratios, index 0..6
    localparam logic [RATIO_W-1:0] RATIO_TAB [RATIO_N] = '{
        11'd128, 11'd192, 11'd256, 11'd384, 11'd512, 11'd768, 11'd1152
    };
    // Speed that each ratio implies when detected
    localparam dss_speed_e RATIO_SPD [RATIO_N] = '{
        SPD_QUAD, SPD_QUAD, SPD_DOUBLE, SPD_DOUBLE, SPD_NORMAL, SPD_NORMAL, SPD_NORMAL
    };
    // Ratios accepted for each manually chosen speed and, as SUP_ALL, in auto mode; one bit per table entry
    localparam logic [RATIO_N-1:0] SUP_NORMAL = 7'h7c;
    localparam logic [RATIO_N-1:0] SUP_DOUBLE = 7'h0f;
    localparam logic [RATIO_N-1:0] SUP_QUAD   = 7'h03;
    localparam logic [RATIO_N-1:0] SUP_ALL    = 7'h7f;

    // Internal clock divider: ratio shifted right by these per speed
    localparam int SHIFT_NORMAL = 7;
    localparam int SHIFT_DOUBLE = 6;
    localparam int SHIFT_QUAD   = 5;
    localparam logic [3:0] DIV_RST = 4'h4;

    localparam logic [RATIO_W-1:0] RATIO_TOL = 11'd1;
    localparam logic [1:0] EDGES_MAX = 2'h2;

    // Host side register map
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_RATIO_LSB = 4;
    localparam logic [2:0] RATIO_IDX_RST = 3'h4;

    // Host timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int RST_PULSE_NS = 150;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] STARTUP_FRAMES = 4'h2;
    localparam int BIT_SHIFT = 6;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_WAKE = 4'b0010,
        H_RUN  = 4'b0100,
        H_HOLD = 4'b1000
    } dss_host_state_e;

endpackage

//--- design/dss_link_if.sv
// Link between the audio clock source and the sampling speed selector
`timescale 1ns/1ps
interface dss_link_if;
    logic master_clock;
    logic frame_clock;
    logic bit_clock;
    logic reset_pin_n;

    modport host (output master_clock, output frame_clock, output bit_clock, output reset_pin_n);
    modport dev  (input master_clock, input frame_clock, input bit_clock, input reset_pin_n);
endinterface

//--- design/dss_device.sv
// Sampling speed selector of the DAC, clocked by the master clock
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
// Operation
// - Source keeps master clock locked to frame
// - Manual mode: speed from speed select field
// - Manual mode: clocking follows ratio without setup
// - Auto mode default: detect ratio, ignore field
// - Parallel, auto pin low: normal speed
// - Parallel, auto pin high: auto detection
// - Parallel: no 128/192 ratios at double
// - Non-slot frame rates per speed band
// - 256-slot mode: normal speed only; code still locks other speeds and only clears rate_ok_o
// - 128-slot mode: normal or double only; code still locks quad and only clears rate_ok_o
// - Reset pin low holds reset state
// - Field codes: 00 normal, 01 double, 10 quad
// - Detected ratio maps to speed
// - Source keeps clocks before releasing reset
module dss_device
    import dss_pkg::*;
(
    dss_link_if.dev                 link,
    input  wire logic               parallel_mode_i,
    input  wire logic               auto_pin_i,
    input  wire logic               auto_speed_select_i,
    input  wire logic [1:0]         speed_select_field_i,
    input  wire logic               slot_mode_enable_i,
    input  wire logic               slot_width_select_i,
    output logic                    in_reset_o,
    output logic                    locked_o,
    output logic [1:0]              speed_o,
    output logic [3:0]              clk_div_o,
    output logic [RATIO_W-1:0]      ratio_o,
    output logic [7:0]              bits_per_frame_o,
    output logic                    int_tick_o,
    output logic                    rate_ok_o
);

    logic                clk;
    logic                rst_s1_q;
    logic                rst_s2_q;
    logic                fr_s1_q;
    logic                fr_s2_q;
    logic                fr_s3_q;
    logic                bk_s1_q;
    logic                bk_s2_q;
    logic                bk_s3_q;
    logic                in_rst;
    logic                fr_rise;
    logic                bk_rise;
    logic [RATIO_W-1:0]  cnt_q;
    logic [1:0]          edges_q;
    logic [7:0]          bcnt_q;
    logic                hit;
    logic [2:0]          idx;
    logic                auto_mode;
    dss_speed_e          target;
    logic                target_ok;
    logic [RATIO_N-1:0]  sup_mask;
    logic [RATIO_W-1:0]  div_full;
    logic                apply;
    dss_speed_e          speed_q;
    logic [3:0]          div_q;
    logic                locked_q;
    logic [RATIO_W-1:0]  ratio_q;
    logic [7:0]          bits_q;
    logic [3:0]          tcnt_q;
    logic                tick_q;
    logic                rate_ok_q;
    logic [6:0]          cfg_s1_q;
    logic [6:0]          cfg_s2_q;
    logic                par_mode;
    logic                auto_pin;
    logic                auto_sel;
    logic [1:0]          field;
    logic                slot_en;
    logic                slot_w;

    assign clk = link.master_clock;

    // Pins come from the source's clock domain; two stages before use
    always_ff @(posedge clk) begin
        rst_s1_q <= link.reset_pin_n;
        rst_s2_q <= rst_s1_q;
        fr_s1_q  <= link.frame_clock;
        fr_s2_q  <= fr_s1_q;
        fr_s3_q  <= fr_s2_q;
        bk_s1_q  <= link.bit_clock;
        bk_s2_q  <= bk_s1_q;
        bk_s3_q  <= bk_s2_q;
        // Mode inputs come from another domain as well; treated like pins
        cfg_s1_q <= {parallel_mode_i, auto_pin_i, auto_speed_select_i, speed_select_field_i,
                     slot_mode_enable_i, slot_width_select_i};
        cfg_s2_q <= cfg_s1_q;
    end

    assign in_rst  = ~rst_s2_q;
    assign fr_rise = fr_s2_q & ~fr_s3_q;
    assign bk_rise = bk_s2_q & ~bk_s3_q;
    assign {par_mode, auto_pin, auto_sel, field, slot_en, slot_w} = cfg_s2_q;

    // Master clock cycles per frame; any fixed phase shifts both edges alike
    always_ff @(posedge clk) begin
        if (in_rst) begin
            cnt_q <= '0;
        end else if (fr_rise) begin
            cnt_q <= 11'd1;
        end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + 11'd1;
        end
    end

    // First edge after reset closes a partial period, so it is not trusted
    always_ff @(posedge clk) begin
        if (in_rst) begin
            edges_q <= '0;
        end else if (fr_rise && edges_q != EDGES_MAX) begin
            edges_q <= edges_q + 2'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (in_rst) begin
            bcnt_q <= '0;
            bits_q <= '0;
        end else if (fr_rise) begin
            bits_q <= bcnt_q;
            bcnt_q <= {7'h00, bk_rise};
        end else if (bk_rise && bcnt_q != '1) begin
            bcnt_q <= bcnt_q + 8'd1;
        end
    end

    // Ratio match with one cycle of slack for sampling jitter
    always_comb begin
        hit = 1'b0;
        idx = '0;
        for (int i = 0; i < RATIO_N; i++) begin
            if (cnt_q + RATIO_TOL >= RATIO_TAB[i] && cnt_q <= RATIO_TAB[i] + RATIO_TOL) begin
                hit = 1'b1;
                idx = 3'(i);
            end
        end
    end

    always_comb begin
        if (par_mode) begin
            auto_mode = auto_pin;
        end else begin
            auto_mode = auto_sel;
        end
        target_ok = 1'b1;
        if (auto_mode) begin
            target   = RATIO_SPD[idx];
            sup_mask = SUP_ALL;
        end else if (par_mode) begin
            target   = SPD_NORMAL;
            sup_mask = SUP_NORMAL;
        end else begin
            case (field)
                2'b00: begin
                    target   = SPD_NORMAL;
                    sup_mask = SUP_NORMAL;
                end
                2'b01: begin
                    target   = SPD_DOUBLE;
                    sup_mask = SUP_DOUBLE;
                end
                2'b10: begin
                    target   = SPD_QUAD;
                    sup_mask = SUP_QUAD;
                end
                default: begin
                    target    = speed_q;
                    sup_mask  = '0;
                    target_ok = 1'b0;
                end
            endcase
        end
        case (target)
            SPD_DOUBLE: div_full = RATIO_TAB[idx] >> SHIFT_DOUBLE;
            SPD_QUAD:   div_full = RATIO_TAB[idx] >> SHIFT_QUAD;
            default:    div_full = RATIO_TAB[idx] >> SHIFT_NORMAL;
        endcase
    end

    assign apply = fr_rise && edges_q != 2'd0 && hit && target_ok && sup_mask[idx];

    // Clocking set from the ratio and the target speed; nothing else to configure
    always_ff @(posedge clk) begin
        if (in_rst) begin
            speed_q  <= SPD_NORMAL;
            div_q    <= DIV_RST;
            locked_q <= 1'b0;
            ratio_q  <= '0;
        end else if (apply) begin
            speed_q  <= target;
            div_q    <= div_full[3:0];
            locked_q <= 1'b1;
            ratio_q  <= RATIO_TAB[idx];
        end
        // Otherwise an unmatched ratio leaves all of it alone
    end

    // Internal clock enable derived from the master clock
    always_ff @(posedge clk) begin
        if (in_rst || !locked_q) begin
            tcnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tcnt_q >= div_q - 4'd1) begin
            tcnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tcnt_q <= tcnt_q + 4'd1;
            tick_q <= 1'b0;
        end
    end

    // Slot modes narrow the allowed speeds; flagged, not enforced
    always_ff @(posedge clk) begin
        if (in_rst) begin
            rate_ok_q <= 1'b1;
        end else if (slot_en && !slot_w) begin
            rate_ok_q <= (speed_q == SPD_NORMAL);
        end else if (slot_en) begin
            rate_ok_q <= (speed_q != SPD_QUAD);
        end else begin
            rate_ok_q <= 1'b1;
        end
    end

    assign in_reset_o       = in_rst;
    assign locked_o         = locked_q;
    assign speed_o          = speed_q;
    assign clk_div_o        = div_q;
    assign ratio_o          = ratio_q;
    assign bits_per_frame_o = bits_q;
    assign int_tick_o       = tick_q;
    assign rate_ok_o        = rate_ok_q;

endmodule // dss_device

//--- design/dss_host.sv
// Audio clock source: makes master, frame and bit clocks and drives the reset pin
`timescale 1ns/1ps
module dss_host
    import dss_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [3:0]   wb_adr_i,
    input  wire logic [31:0]  wb_dat_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic         wb_we_i,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    output logic              wb_ack_o,
    output logic [31:0]       wb_dat_o,
    dss_link_if.host          link
);

    dss_host_state_e      state_q;
    logic                 run_q;
    logic [2:0]           ratio_sel_q;
    logic [RATIO_W-1:0]   ratio_q;
    logic                 ack_q;
    logic [31:0]          dat_q;
    logic                 req;
    logic                 mclk_q;
    logic                 frame_q;
    logic                 bit_q;
    logic                 rstn_q;
    logic                 clk_on;
    logic                 fall;
    logic [RATIO_W-1:0]   mcnt_q;
    logic [RATIO_W-1:0]   bcnt_q;
    logic [RATIO_W-1:0]   bhalf;
    logic [3:0]           frames_q;
    logic [3:0]           hold_q;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q       <= 1'b0;
            ratio_sel_q <= RATIO_IDX_RST;
        end else if (req && wb_we_i && wb_adr_i == CTRL_OFS && wb_sel_i[0]) begin
            run_q       <= wb_dat_i[CTRL_RUN_BIT];
            ratio_sel_q <= wb_dat_i[CTRL_RATIO_LSB+:3];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= '0;
        end else if (req) begin
            case (wb_adr_i)
                CTRL_OFS:   dat_q <= {25'h0, ratio_sel_q, 3'h0, run_q};
                STATUS_OFS: dat_q <= {24'h0, state_q, 2'h0, clk_on, rstn_q};
                default:    dat_q <= '0;
            endcase
        end
    end

    // Clocks run from wake-up until the hold after reset falls ends
    assign clk_on = (state_q == H_WAKE) || (state_q == H_RUN) || (state_q == H_HOLD);
    assign fall   = clk_on & mclk_q;
    assign bhalf  = ratio_q >> BIT_SHIFT;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q  <= H_IDLE;
            ratio_q  <= RATIO_TAB[RATIO_IDX_RST];
            rstn_q   <= 1'b0;
            hold_q   <= '0;
        end else begin
            case (state_q)
                H_IDLE: begin
                    rstn_q <= 1'b0;
                    if (run_q) begin
                        state_q <= H_WAKE;
                        ratio_q <= (ratio_sel_q < 3'(RATIO_N)) ? RATIO_TAB[ratio_sel_q]
                                                               : RATIO_TAB[RATIO_IDX_RST];
                    end
                end
                H_WAKE: begin
                    // Reset stays low until whole frames have gone out
                    if (!run_q) begin
                        state_q <= H_HOLD;
                        hold_q  <= '0;
                    end else if (frames_q >= STARTUP_FRAMES) begin
                        state_q <= H_RUN;
                        rstn_q  <= 1'b1;
                    end
                end
                H_RUN: begin
                    if (!run_q) begin
                        state_q <= H_HOLD;
                        rstn_q  <= 1'b0;
                        hold_q  <= '0;
                    end
                end
                H_HOLD: begin
                    // Clocks outlive the falling reset for a full pulse width
                    if (hold_q >= 4'(RST_PULSE_CYC)) begin
                        state_q <= H_IDLE;
                    end else begin
                        hold_q <= hold_q + 4'd1;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                    rstn_q  <= 1'b0;
                end
            endcase
        end
    end

    // Frame and bit clocks change as the master clock falls, and clear when the clocks stop
    always_ff @(posedge clk_i) begin
        if (rst_i || !clk_on) begin
            mclk_q   <= 1'b0;
            frame_q  <= 1'b0;
            bit_q    <= 1'b0;
            mcnt_q   <= '0;
            bcnt_q   <= '0;
            frames_q <= '0;
        end else begin
            mclk_q <= ~mclk_q;
            if (fall) begin
                if (mcnt_q == ratio_q - 11'd1) begin
                    mcnt_q  <= '0;
                    bcnt_q  <= '0;
                    frame_q <= 1'b1;
                    bit_q   <= 1'b0;
                    if (frames_q != '1) begin
                        frames_q <= frames_q + 4'd1;
                    end
                end else begin
                    mcnt_q <= mcnt_q + 11'd1;
                    if (mcnt_q == (ratio_q >> 1) - 11'd1) begin
                        frame_q <= 1'b0;
                    end
                    if (bcnt_q == bhalf - 11'd1) begin
                        bcnt_q <= '0;
                        bit_q  <= ~bit_q;
                    end else begin
                        bcnt_q <= bcnt_q + 11'd1;
                    end
                end
            end
        end
    end

    assign wb_ack_o           = ack_q;
    assign wb_dat_o           = dat_q;
    assign link.master_clock  = mclk_q;
    assign link.frame_clock   = frame_q;
    assign link.bit_clock     = bit_q;
    assign link.reset_pin_n   = rstn_q;

endmodule // dss_host

//--- testbench/dss_asserts.sv
// Concurrent checks on the link and the speed selector outputs
`timescale 1ns/1ps
module dss_asserts
    import dss_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               master_clock,
    input wire logic               frame_clock,
    input wire logic               reset_pin_n,
    input wire logic               parallel_mode_i,
    input wire logic               auto_pin_i,
    input wire logic               auto_speed_select_i,
    input wire logic [1:0]         speed_select_field_i,
    input wire logic               slot_mode_enable_i,
    input wire logic               slot_width_select_i,
    input wire logic               in_reset_o,
    input wire logic               locked_o,
    input wire logic [1:0]         speed_o,
    input wire logic [3:0]         clk_div_o,
    input wire logic [RATIO_W-1:0] ratio_o,
    input wire logic               rate_ok_o,
    input wire logic               int_tick_o
);
    logic       auto_on;
    logic [3:0] tick_gap_q;
    logic [1:0] auto_spd;
    logic [3:0] div_exp;
    // Thresholds midway between table ratios absorb the +-1 tolerance
    assign auto_on  = parallel_mode_i ? auto_pin_i : auto_speed_select_i;
    assign auto_spd = (ratio_o < 11'd224) ? 2'b10 : (ratio_o < 11'd448) ? 2'b01 : 2'b00;
    assign div_exp  = 4'(ratio_o >> (7 - int'(speed_o)));

    // Master clock cycles since the last internal tick
    always_ff @(posedge master_clock) begin
        tick_gap_q <= int_tick_o ? 4'h1 : tick_gap_q + 4'h1;
    end

    a_mclk_runs: assert property (@(posedge clk_i) disable iff (rst_i)
        reset_pin_n |-> master_clock != $past(master_clock))
        else $error("master clock stalled while reset released");
    a_frame_on_fall: assert property (@(posedge clk_i) disable iff (rst_i)
        // A stopping source may drop the frame level with the master clock already low
        $changed(frame_clock) && $changed(master_clock) |-> $fell(master_clock))
        else $error("frame clock moved off the master clock fall");
    // Sync flops need master clock edges, so only a held-low pin is judged
    a_reset_held: assert property (@(posedge master_clock) disable iff (rst_i)
        (!reset_pin_n) [*3] |-> in_reset_o)
        else $error("reset pin low but device not in reset");
    a_reset_vals: assert property (@(posedge master_clock) disable iff (rst_i)
        in_reset_o [*2] |-> speed_o == 2'b00 && clk_div_o == DIV_RST && !locked_o
            && ratio_o == '0 && rate_ok_o)
        else $error("outputs not at reset values");
    a_div_speed: assert property (@(posedge master_clock) disable iff (!reset_pin_n)
        locked_o |-> clk_div_o == div_exp)
        else $error("divider does not match speed and ratio");
    a_auto_map: assert property (@(posedge master_clock) disable iff (!reset_pin_n)
        locked_o && auto_on |-> speed_o == auto_spd)
        else $error("detected speed wrong for ratio");
    a_manual_field: assert property (@(posedge master_clock) disable iff (!reset_pin_n)
        locked_o && !parallel_mode_i && !auto_speed_select_i |-> speed_o == speed_select_field_i)
        else $error("manual speed differs from field");
    a_pin_normal: assert property (@(posedge master_clock) disable iff (!reset_pin_n)
        locked_o && parallel_mode_i && !auto_pin_i |-> speed_o == SPD_NORMAL)
        else $error("pin mode low not at normal speed");
    a_slot_limit: assert property (@(posedge master_clock) disable iff (!reset_pin_n)
        locked_o && $past(locked_o) && $stable(speed_o) |-> rate_ok_o == !(slot_mode_enable_i
            && (slot_width_select_i ? speed_o == 2'b10 : speed_o != 2'b00)))
        else $error("slot mode rate flag wrong");
    a_tick_period: assert property (@(posedge master_clock) disable iff (!reset_pin_n)
        locked_o && $past(locked_o, 10) && int_tick_o |-> tick_gap_q == clk_div_o)
        else $error("internal tick period differs from divider");
endmodule // dss_asserts

//--- testbench/dss_sampling_speed_select_bench.sv
// Bench: clock source and speed selector joined over the link
`timescale 1ns/1ps
module dss_sampling_speed_select_bench;
    import dss_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  adr   = '0;
    logic [31:0] wdat  = '0;
    logic        we    = 1'b0;
    logic        stb   = 1'b0;
    logic        pm    = 1'b0;
    logic        ap    = 1'b0;
    logic        as    = 1'b1;
    logic [1:0]  fld   = '0;
    logic        se    = 1'b0;
    logic        sw    = 1'b0;
    logic        ack;
    logic [31:0] rdat;
    logic        in_rst;
    logic        locked;
    logic [1:0]  spd;
    logic [3:0]  div;
    logic [10:0] ratio;
    logic        rok;
    logic        tick;
    logic [7:0]  bpf;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    int          rt [7]     = '{128, 192, 256, 384, 512, 768, 1152};

    dss_link_if link ();
    dss_host u_dss_host (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb), .wb_ack_o(ack),
        .wb_dat_o(rdat), .link(link.host));
    dss_device u_dss_device (.link(link.dev), .parallel_mode_i(pm), .auto_pin_i(ap),
        .auto_speed_select_i(as), .speed_select_field_i(fld), .slot_mode_enable_i(se),
        .slot_width_select_i(sw), .in_reset_o(in_rst), .locked_o(locked), .speed_o(spd),
        .clk_div_o(div), .ratio_o(ratio), .bits_per_frame_o(bpf), .int_tick_o(tick),
        .rate_ok_o(rok));
    dss_asserts u_dss_asserts (.clk_i(clk_i), .rst_i(rst_i), .master_clock(link.master_clock),
        .frame_clock(link.frame_clock), .reset_pin_n(link.reset_pin_n), .parallel_mode_i(pm),
        .auto_pin_i(ap), .auto_speed_select_i(as), .speed_select_field_i(fld),
        .slot_mode_enable_i(se), .slot_width_select_i(sw), .in_reset_o(in_rst),
        .locked_o(locked), .speed_o(spd), .clk_div_o(div), .ratio_o(ratio), .rate_ok_o(rok),
        .int_tick_o(tick));

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Expected {bits per frame, lock, speed, divider, rate flag, ratio} of one setup
    function automatic logic [31:0] exp_word(input int md, input int idx, input logic [1:0] f,
                                             input logic s0, input logic s1);
        logic [10:0] r;
        logic [1:0]  sp;
        logic        ok;
        r  = 11'(rt[idx]);
        sp = (idx < 2) ? 2'b10 : (idx < 4) ? 2'b01 : 2'b00;
        ok = 1'b1;
        if (md == 2) begin
            sp = 2'b00;
            ok = (r >= 256);
        end else if (md == 1) begin
            sp = f;
            ok = (f == 0) ? r >= 256 : (f == 1) ? r <= 384 : (f == 2) ? r <= 192 : 1'b0;
        end
        if (!ok)
            return {5'h0, 8'h20, 1'b0, 2'b00, 4'h4, 1'b1, 11'h0};
        return {5'h0, 8'h20, 1'b1, sp, 4'(r >> (7 - sp)),
                !(s0 && (s1 ? sp == 2'b10 : sp != 2'b00)), r};
    endfunction

    // One classic cycle; cyc and stb share a net so they rise and fall together
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        we <= w;
        stb <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = rdat;
        if (n >= 20)
            n_mismatch++;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // md: 0 serial auto, 1 serial manual, 2 pin mode low, 3 pin mode high
    task automatic run_case(input int md, input int idx, input logic [1:0] f);
        int          n;
        logic [10:0] r;
        logic        s0;
        logic        s1;
        wb(1'b1, CTRL_OFS, 32'(idx << 4), q);
        n = 0;
        do begin
            wb(1'b0, STATUS_OFS, '0, q);
            n++;
        end while (q[7:4] !== 4'h1 && n < 50);
        chk(32'(q[7:0]), 32'h10);
        s0 = 1'($urandom);
        s1 = 1'($urandom);
        r = 11'(rt[idx]);
        pm <= md[1];
        ap <= md[0];
        as <= (md == 0);
        fld <= f;
        se <= s0;
        sw <= s1;
        wb(1'b1, CTRL_OFS, 32'((idx << 4) | 1), q);
        n = 0;
        // A lock left from the last run is stale until the pin has held reset
        while (link.reset_pin_n !== 1'b1 && n < 8 * r) begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        // Refused setups wait the whole span: absence of lock is the point
        while (locked !== 1'b1 && n < 8 * r) begin
            @(posedge clk_i);
            n++;
        end
        repeat (4) @(posedge clk_i);
        chk({5'h0, bpf, locked, spd, div, rok, ratio}, exp_word(md, idx, f, s0, s1));
        wb(1'b0, STATUS_OFS, '0, q);
        chk(32'(q[7:0]), 32'h43);
    endtask

    initial begin
        void'($urandom(60));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, CTRL_OFS, '0, q);
        chk(q, 32'h40);
        wb(1'b0, STATUS_OFS, '0, q);
        chk(q, 32'h10);
        wb(1'b1, 4'h8, 32'hff, q);
        wb(1'b0, 4'h8, '0, q);
        chk(q, 32'h0);
        for (int i = 0; i < 7; i++)
            run_case(0, i, 2'(i));
        for (int f = 0; f < 3; f++)
            run_case(1, (f == 0) ? 2 + int'($urandom % 5) : int'($urandom % (4 - 2 * (f - 1))),
                     2'(f));
        run_case(1, 4, 2'b11);
        run_case(1, 4, 2'b10);
        run_case(2, 6, 2'b10);
        run_case(3, 0, 2'b01);
        stop_test;
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        n_mismatch++;
        stop_test;
    end
endmodule // dss_sampling_speed_select_bench
